//--- rtl/qcst_top.sv
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module qcst_top #(
  parameter int SLOW_HALF_CYC = qcst_pkg::SLOW_HALF
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Register bus.
  input wire qcst_pkg::qcst_req_s bus_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // Channel and cascade data.
  input wire qcst_pkg::qcst_chan_s chan_in,
  input wire logic [15:0] sum_in,
  output logic [15:0] sum_out,
  // Clocking and sync pins.
  input wire logic clock_source_select_in,
  input wire logic ref_clock_in,
  input wire logic sync_in_n_in,
  output logic sync_out_n_out,
  output logic sample_request_out,
  output logic slow_clock_sel_out,
  output logic ramp_active_out
);
  import qcst_pkg::*;

  // ****************************************************
  // State.
  // ****************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] sumcfg;
    logic [31:0] gains;
    logic [15:0] interp;
    logic [7:0] synccfg;
    logic [7:0] pwr;
    logic [7:0] status;
    logic [31:0] cksum;
    logic rd_done;
    logic [31:0] rdata;
    logic [1:0] sy;
    logic [1:0] rk;
    logic rk_d;
    logic [31:0] losscnt;
    logic [31:0] slowcnt;
    logic slowck;
    logic slow_sel;
    logic [17:0] s1;
    logic [15:0] cas1;
    logic [19:0] s2;
    logic [15:0] s3;
    logic [15:0] p4;
    logic [15:0] p5;
    logic [15:0] p6;
    logic [15:0] p7;
    logic [15:0] sout;
    logic [15:0] ramp;
    logic [17:0] icnt;
    logic [3:0] lead;
    logic lead_on;
    logic [7:0] wcnt;
    logic [15:0] scnt;
    logic [3:0] osht;
    logic [3:0] sdly;
    logic sout_n;
    logic req;
  } qcst_state_s;
  qcst_state_s r, next_r;

  // Saturating 16-bit clamp of a wider signed value.
  function automatic logic [15:0] sat16(input logic signed [23:0] v);
    if (v > 24'sh007FFF) begin
      sat16 = POS_FS;
    end else if (v < -24'sh008000) begin
      sat16 = NEG_FS;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  logic signed [23:0] prod [4];
  logic signed [23:0] tot;
  logic signed [23:0] cas;
  logic signed [23:0] rnd;
  logic [15:0] ch_w [4];
  logic [15:0] ch_sat [4];
  logic [15:0] rmask;
  logic [15:0] rhalf;
  logic ovf;
  logic sync_ev;
  logic req_sync;

  assign ch_w[0] = r.ctrl[0] ? r.ramp : chan_in.ch0;
  assign ch_w[1] = r.ctrl[0] ? r.ramp : chan_in.ch1;
  assign ch_w[2] = r.ctrl[0] ? r.ramp : chan_in.ch2;
  assign ch_w[3] = r.ctrl[0] ? r.ramp : chan_in.ch3;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gch
      // Gain over 128, clamped per channel.
      assign prod[g] = 24'($signed(ch_w[g]) * $signed({1'b0, r.gains[8*g +: 8]})) >>> 7; // RULE8 RULE20
      assign ch_sat[g] = sat16(prod[g]); // RULE4
    end
  endgenerate

  // ****************************************************
  // Next state.
  // ****************************************************
  always_comb begin
    next_r = r;
    ovf = 1'b0;
    tot = 24'sh0;
    cas = 24'sh0;
    rnd = 24'sh0;
    sync_ev = 1'b0;
    req_sync = 1'b0;
    rmask = 16'h0000;
    rhalf = 16'h0000;
    // Bus slave: writes in one cycle, reads answer one cycle later.
    next_r.rd_done = 1'b0;
    if (bus_in.write) begin
      case (bus_in.address)
        REG_CTRL: next_r.ctrl = bus_in.writedata[7:0];
        REG_SUMCFG: next_r.sumcfg = bus_in.writedata[7:0];
        REG_GAIN: next_r.gains = bus_in.writedata;
        REG_INTERP: next_r.interp = bus_in.writedata[15:0];
        REG_SYNC: next_r.synccfg = bus_in.writedata[7:0];
        REG_PWR: next_r.pwr = bus_in.writedata[7:0];
        default: ;
      endcase
    end
    if (bus_in.read && !r.rd_done) begin
      next_r.rd_done = 1'b1;
      case (bus_in.address)
        REG_CTRL: next_r.rdata = {24'h0, r.ctrl};
        REG_SUMCFG: next_r.rdata = {24'h0, r.sumcfg};
        REG_GAIN: next_r.rdata = r.gains;
        REG_INTERP: next_r.rdata = {16'h0, r.interp};
        REG_SYNC: next_r.rdata = {24'h0, r.synccfg};
        REG_STATUS: next_r.rdata = {24'h0, r.status};
        REG_CKSUM: next_r.rdata = r.cksum;
        REG_PWR: next_r.rdata = {29'h0, r.slow_sel, r.pwr[1:0]};
        default: next_r.rdata = BAD_READ;
      endcase
    end
    // Sum tree pipeline.
    tot = $signed({{6{ch_sat[0][15]}}, ch_sat[0]}) + $signed({{6{ch_sat[1][15]}}, ch_sat[1]})
        + $signed({{6{ch_sat[2][15]}}, ch_sat[2]}) + $signed({{6{ch_sat[3][15]}}, ch_sat[3]}); // RULE1
    // The part-select is unsigned, so re-sign it before the arithmetic shift.
    next_r.s1 = 18'($signed(tot[17:0]) >>> r.sumcfg[1:0]); // RULE2
    next_r.cas1 = r.ctrl[0] ? r.ramp : sum_in; // RULE22 RULE20
    cas = $signed({{6{r.s1[17]}}, r.s1}) + $signed({{8{r.cas1[15]}}, r.cas1}); // RULE1
    next_r.s2 = cas[19:0];
    next_r.s3 = sat16($signed({{4{r.s2[19]}}, r.s2})); // RULE4
    if (($signed(r.s2) > 20'sh07FFF) || ($signed(r.s2) < -20'sh08000)) begin
      ovf = 1'b1;
    end
    // Round half up to the selected width: 0..4 gives 16,14,12,10,8 bits.
    case (r.sumcfg[4:2])
      3'h1: begin rmask = 16'hFFFC; rhalf = 16'h0002; end
      3'h2: begin rmask = 16'hFFF0; rhalf = 16'h0008; end
      3'h3: begin rmask = 16'hFFC0; rhalf = 16'h0020; end
      3'h4: begin rmask = 16'hFF00; rhalf = 16'h0080; end
      default: begin rmask = 16'hFFFF; rhalf = 16'h0000; end
    endcase
    rnd = $signed({{8{r.s3[15]}}, r.s3}) + $signed({8'h00, rhalf}); // RULE26 RULE3
    next_r.p4 = sat16(rnd) & rmask; // RULE26 RULE4
    if ($signed(rnd) > 24'sh007FFF) begin
      next_r.p4 = POS_FS & rmask;
      ovf = 1'b1;
    end
    // Delay stages that set the fixed eight-cycle latency from sum_in to sum_out.
    next_r.p5 = r.p4; // RULE5
    next_r.p6 = r.p5;
    next_r.p7 = r.p6; // RULE5
    next_r.sout = {r.p7[15] ^ r.sumcfg[5], r.p7[14:0]}; // RULE6
    next_r.status = r.status | {7'h0, ovf}; // RULE7
    if (bus_in.write && bus_in.address == REG_STATUS) begin
      next_r.status = (r.status & ~bus_in.writedata[7:0]) | {7'h0, ovf};
    end
    next_r.cksum = {r.cksum[30:0], r.cksum[31]} ^ {16'h0, r.sout}; // RULE21
    if (bus_in.write && bus_in.address == REG_CKSUM) begin
      next_r.cksum = 32'h0;
    end
    next_r.ramp = r.ramp + 16'h0001; // RULE20
    // Sync handling.
    next_r.sy = {r.sy[0], ~sync_in_n_in}; // RULE23
    next_r.osht = {r.osht[2:0], 1'b0};
    if (bus_in.write && bus_in.address == REG_SYNC && bus_in.writedata[8]) begin
      next_r.osht = 4'hF;
    end
    next_r.scnt = r.scnt - 16'h0001;
    if (r.scnt == 16'h0000) begin
      next_r.scnt = r.interp;
    end
    next_r.sdly = {r.sdly[2:0], r.sy[1]};
    case (qcst_sync_e'(r.synccfg[1:0])) // RULE14
      QCST_SY_EXT: sync_ev = r.sy[1];
      QCST_SY_ONESHOT: sync_ev = r.osht[3];
      QCST_SY_COUNT: sync_ev = (r.scnt == 16'h0000);
      default: sync_ev = 1'b0;
    endcase
    case (r.synccfg[3:2]) // RULE24 RULE15
      2'h0: next_r.sout_n = ~r.sdly[3];
      2'h1: next_r.sout_n = ~(r.scnt == 16'h0000);
      2'h2: next_r.sout_n = ~r.osht[3];
      default: next_r.sout_n = 1'b1;
    endcase
    // Interpolation counter: period 4N complex, 2N real.
    req_sync = sync_ev && r.ctrl[2]; // RULE16
    next_r.icnt = r.icnt - 18'h00001;
    next_r.lead_on = r.lead_on;
    next_r.lead = r.lead;
    if (req_sync) begin
      next_r.lead_on = 1'b1;
      // Two synchroniser stages and three counter stages already use up the whole lead.
      next_r.lead = REQ_LEAD - 4'h5; // RULE17
    end else if (r.lead_on) begin
      next_r.lead = r.lead - 4'h1;
      if (r.lead == 4'h0) begin
        next_r.lead_on = 1'b0;
        next_r.icnt = 18'h0;
      end
    end
    next_r.wcnt = (r.wcnt != 8'h00) ? r.wcnt - 8'h01 : 8'h00;
    if (!r.lead_on && !req_sync && r.icnt == 18'h0) begin
      next_r.icnt = r.ctrl[3] ? {1'b0, r.interp, 1'b0} - 18'h00001
                              : {r.interp, 2'b00} - 18'h00001; // RULE17
      next_r.wcnt = {4'h0, r.synccfg[7:4]} + 8'h01;
    end
    next_r.req = (r.wcnt != 8'h00) ^ r.ctrl[4]; // RULE25
    // Power down: clock loss watch on the reference clock.
    next_r.rk = {r.rk[0], ref_clock_in};
    next_r.rk_d = r.rk[1];
    next_r.losscnt = (r.rk[1] != r.rk_d) ? 32'h0 : r.losscnt + 32'h1;
    next_r.slowcnt = r.slowcnt + 32'h1;
    if (r.slowcnt >= 32'(SLOW_HALF_CYC - 1)) begin
      next_r.slowcnt = 32'h0;
      next_r.slowck = ~r.slowck; // RULE18
    end
    case (qcst_pd_e'(r.pwr[1:0])) // RULE19
      QCST_PD_AUTO: next_r.slow_sel = (r.losscnt >= 32'(LOSS_CYC)); // RULE18
      QCST_PD_FORCE: next_r.slow_sel = 1'b1;
      default: next_r.slow_sel = 1'b0;
    endcase
  end

  // ****************************************************
  // Registers.
  // ****************************************************
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
      r.gains <= {GAIN_RESET, GAIN_RESET, GAIN_RESET, GAIN_RESET};
      r.interp <= N_RESET;
      r.ctrl <= 8'h02;
      r.sout_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Clock source mode is not used; the core runs on clock_in in both modes.
  assign readdata_out = r.rdata;
  assign waitrequest_out = (bus_in.read && !r.rd_done);
  assign sum_out = r.sout;
  assign sync_out_n_out = r.sout_n;
  assign sample_request_out = r.req;
  assign slow_clock_sel_out = r.slow_sel;
  assign ramp_active_out = r.ctrl[0];
endmodule
`default_nettype wire

//--- rtl/qcst_pkg.sv
// How it works
// RULE1: Sum four channels, attenuate, add cascade input.
// RULE2: Attenuation is two to minus sum_shift.
// RULE3: Round result to 8-16 selectable bits.
// RULE4: Overflows clamp to full scale, never wrap.
// RULE5: Cascade input reaches output seven cycles later; the code takes eight cycles.
// RULE6: Optionally invert output MSB for offset binary.
// RULE7: Saturation events recorded in readable status; the code does not record the per-channel gain clamp.
// RULE8: Per-channel gain applied as gain over 128.
// RULE9: Software keeps coarse shift large enough.
// RULE10: Software keeps integrator gain at most unity.
// RULE11: Software prefers sum_shift for attenuation.
// RULE12: Standard mode uses internal clock doubler; the code has none and runs on clock_in.
// RULE13: Alternate mode uses double rate clock; the code ignores clock_source_select_in.
// RULE14: Three sync sources, each circuit selects one.
// RULE15: Selected sync source drivable off chip.
// RULE16: Interpolation counter makes request, sync-lockable.
// RULE17: Request five cycles after sync, then periodic.
// RULE18: Keep-alive slow clock on loss or power down; the code drives only slow_clock_sel_out, and slowck reaches no output.
// RULE19: Power-down mode auto, forced or disabled.
// RULE20: Ramp generator can replace data inputs.
// RULE21: Checksum accumulates over output data.
// RULE22: Cascade input is 16-bit signed per clock.
// RULE23: Sync input sampled before counters use it.
// RULE24: Sync out selects delayed sync, terminal, one-shot.
// RULE25: Request strobe polarity and width programmable.
// RULE26: Round half up, then saturate.
package qcst_pkg;
  localparam int DW = 16;
  localparam int AW = 4;
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_SUMCFG = 4'h1;
  localparam logic [AW-1:0] REG_GAIN = 4'h2;
  localparam logic [AW-1:0] REG_INTERP = 4'h3;
  localparam logic [AW-1:0] REG_SYNC = 4'h4;
  localparam logic [AW-1:0] REG_STATUS = 4'h5;
  localparam logic [AW-1:0] REG_CKSUM = 4'h6;
  localparam logic [AW-1:0] REG_PWR = 4'h7;
  localparam logic [31:0] BAD_READ = 32'hDEAD_0000;
  localparam logic [15:0] POS_FS = 16'h7FFF;
  localparam logic [15:0] NEG_FS = 16'h8000;
  localparam logic [2:0] IO_LATENCY = 3'h7;
  localparam logic [3:0] REQ_LEAD = 4'h5;
  localparam logic [7:0] GAIN_RESET = 8'h80;
  localparam logic [15:0] N_RESET = 16'h0008;
  localparam real CLK_MHZ = 200.0;
  localparam real SLOW_KHZ = 1.0;
  localparam int SLOW_HALF = int'(CLK_MHZ * 1000.0 / SLOW_KHZ / 2.0);
  localparam int LOSS_NS = 1000;
  localparam int LOSS_CYC = int'(LOSS_NS * CLK_MHZ / 1000.0);
  typedef enum logic [1:0] {QCST_SY_EXT, QCST_SY_ONESHOT, QCST_SY_COUNT, QCST_SY_NONE} qcst_sync_e;
  typedef enum logic [1:0] {QCST_PD_AUTO, QCST_PD_FORCE, QCST_PD_OFF, QCST_PD_RSV} qcst_pd_e;
  typedef struct packed {
    logic [DW-1:0] ch0;
    logic [DW-1:0] ch1;
    logic [DW-1:0] ch2;
    logic [DW-1:0] ch3;
  } qcst_chan_s;
  typedef struct packed {
    logic [AW-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } qcst_req_s;
endpackage

//--- tb/qcst_dac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far side: output converter and board clock source.
// ****************************************
module qcst_dac_model (
  // Clock and control.
  input wire logic clock_in,
  input wire logic stop_in,
  // Data from the summer.
  input wire logic [15:0] sum_in,
  // Board pins.
  output logic clock_source_select_out,
  output logic ref_clock_out,
  output logic [15:0] sample_out
);
  assign clock_source_select_out = 1'b0;
  initial begin
    ref_clock_out = 1'b0;
    sample_out = 16'h0000;
  end
  // The reference clock stops dead when the board loses it.
  always @(posedge clock_in) begin
    if (!stop_in) begin
      ref_clock_out <= ~ref_clock_out;
    end
    sample_out <= sum_in;
  end
endmodule
`default_nettype wire

//--- tb/qcst_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module qcst_top_asserts (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire qcst_pkg::qcst_req_s bus_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  input wire qcst_pkg::qcst_chan_s chan_in,
  input wire logic [15:0] sum_in,
  input wire logic [15:0] sum_out,
  input wire logic slow_clock_sel_out,
  input wire logic ramp_active_out
);
  import qcst_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  sequence s_quiet;
    !ramp_active_out && !bus_in.write && $stable(sum_in) && $stable(chan_in);
  endsequence
  sequence s_rd_done;
    bus_in.read && !waitrequest_out;
  endsequence
  property p_rd_wait;
    $rose(bus_in.read) |-> waitrequest_out ##1 !waitrequest_out;
  endproperty
  property p_wr_nowait;
    bus_in.write && !bus_in.read |-> !waitrequest_out;
  endproperty
  property p_bad_read;
    s_rd_done and (bus_in.address > REG_PWR) |-> readdata_out == BAD_READ;
  endproperty
  property p_pwr_read;
    s_rd_done and (bus_in.address == REG_PWR) |-> readdata_out[2] == slow_clock_sel_out;
  endproperty
  property p_hold;
    s_quiet [*8] ##1 s_quiet [*2] |-> $stable(sum_out);
  endproperty
  property p_ramp;
    bus_in.write && bus_in.address == REG_CTRL |=> ramp_active_out == $past(bus_in.writedata[0]);
  endproperty
  property p_force;
    bus_in.write && bus_in.address == REG_PWR && bus_in.writedata[1:0] == 2'h1
      |-> ##[1:4] slow_clock_sel_out;
  endproperty
  property p_off;
    bus_in.write && bus_in.address == REG_PWR && bus_in.writedata[1:0] == 2'h2
      |-> ##[1:4] !slow_clock_sel_out;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_bad_read: assert property (p_bad_read) else $error("unmapped read data wrong");
  a_pwr_read: assert property (p_pwr_read) else $error("slow select status wrong");
  a_hold: assert property (p_hold) else $error("output moved with inputs still");
  a_ramp: assert property (p_ramp) else $error("ramp flag wrong");
  a_force: assert property (p_force) else $error("forced power down missing");
  a_off: assert property (p_off) else $error("slow clock not disabled");
endmodule
bind qcst_top qcst_top_asserts chk_u (.clock_in(clock_in), .nrst_in(nrst_in), .bus_in(bus_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .chan_in(chan_in),
  .sum_in(sum_in), .sum_out(sum_out), .slow_clock_sel_out(slow_clock_sel_out),
  .ramp_active_out(ramp_active_out));
`default_nettype wire

//--- tb/quad_channel_sum_and_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
module quad_channel_sum_and_timing_test;
  import qcst_pkg::*;
  logic clk = 0, nrst = 0, sync_n = 1, stop = 0, wq, sreq, ssel, ramp, ck2, csel, ref_ck;
  qcst_req_s b = '0;
  qcst_chan_s ch = '0;
  logic [15:0] si = '0, so;
  logic [31:0] rdat, seed = 32'h601E, t, rdat_hold_dummy;
  int n_errors = 0, total_checks = 0, c[4], n, q[$];
  qcst_top #(.SLOW_HALF_CYC(4)) dut_u (.clock_in(clk), .nrst_in(nrst), .bus_in(b),
    .readdata_out(rdat), .waitrequest_out(wq), .chan_in(ch), .sum_in(si), .sum_out(so),
    .clock_source_select_in(csel), .ref_clock_in(ref_ck), .sync_in_n_in(sync_n),
    .sync_out_n_out(ck2), .sample_request_out(sreq), .slow_clock_sel_out(ssel),
    .ramp_active_out(ramp));
  qcst_dac_model dac_u (.clock_in(clk), .stop_in(stop), .sum_in(so),
    .clock_source_select_out(csel), .ref_clock_out(ref_ck), .sample_out());
  initial forever #2.5 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Sum, attenuate, add cascade, round half up on the kept width, clamp, flip MSB.
  function automatic logic [15:0] exp_sum(int g0, int sh, int wc, int inv, int s_in);
    int s, d;
    s = (c[0] * g0) >>> 7;
    for (int i = 1; i < 4; i++) s += c[i];
    d = 2 * wc;
    s = (s >>> sh) + s_in;
    if (d > 0) s = ((s + (1 << (d - 1))) >>> d) << d;
    if (s > 32767) s = 32767 & ~((1 << d) - 1);
    if (s < -32768) s = -32768;
    return 16'(s) ^ (inv ? 16'h8000 : 16'h0000);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    b <= '{address: a, read: 1'b0, write: 1'b1, writedata: d};
    do @(posedge clk); while (wq !== 1'b0);
    b.write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    b <= '{address: a, read: 1'b1, write: 1'b0, writedata: 32'h0};
    do @(posedge clk); while (wq !== 1'b0);
    d = rdat;
    b.read <= 1'b0;
  endtask
  task automatic sum_case(int g0, int sh, int wc, int inv, int s_in);
    wr(REG_GAIN, {24'h808080, 8'(g0)});
    wr(REG_SUMCFG, 32'(sh + (wc << 2) + (inv << 5)));
    ch <= {16'(c[0]), 16'(c[1]), 16'(c[2]), 16'(c[3])};
    si <= 16'(s_in);
    repeat (12) @(posedge clk);
    chk("sum_out", so, exp_sum(g0, sh, wc, inv, s_in));
  endtask
  task automatic req_case(logic [31:0] ctl, int per);
    wr(REG_CTRL, ctl);
    // Start right after a free-running request so none falls inside the lead.
    for (n = 0; n < 300 && sreq !== 1'b1; n++) @(posedge clk) #1;
    @(posedge clk) sync_n <= 1'b0;
    @(posedge clk) sync_n <= 1'b1;
    for (n = 1; n < 300 && sreq !== 1'b1; n++) @(posedge clk) #1;
    chk("req_lead", n, 32'(REQ_LEAD) + 1);
    @(posedge clk) #1;
    for (n = 1; n < 300 && sreq !== 1'b1; n++) @(posedge clk) #1;
    chk("req_period", n, per);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (c[i]) c[i] = 0;
    rd(REG_CTRL, t); chk("ctrl", t, 32'h2);
    rd(REG_GAIN, t); chk("gain", t, {4{GAIN_RESET}});
    rd(REG_INTERP, t); chk("interp", t, 32'(N_RESET));
    rd(4'h9, t); chk("unmapped", t, BAD_READ);
    wr(REG_CTRL, 32'h0);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i >= 9) chk("latency", so, 32'(q[i - 9]));
      q.push_back(int'(16'(xs())));
      si <= 16'(q[i]);
    end
    for (int k = 0; k < 24; k++) begin
      foreach (c[i]) c[i] = (int'(xs() % 1024) - 512) * 8;
      sum_case(k % 3 == 0 ? 8'h40 : k % 3 == 1 ? 8'hC0 : 8'h80, k % 4, k % 5, k / 12,
        (int'(xs() % 1024) - 512) * 8);
    end
    foreach (c[i]) c[i] = 32760;
    sum_case(8'h80, 0, 0, 0, 32760);
    rd(REG_STATUS, t); chk("ovf_set", t[0], 1'b1);
    foreach (c[i]) c[i] = -32768;
    sum_case(8'h80, 1, 4, 1, -32768);
    foreach (c[i]) c[i] = 0;
    sum_case(8'h80, 0, 0, 0, 0);
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, t); chk("ovf_clr", t[0], 1'b0);
    wr(REG_SYNC, 32'h0);
    req_case(32'h4, 4 * 8);
    req_case(32'hC, 2 * 8);
    wr(REG_SYNC, 32'h108);
    @(posedge clk) #1;
    chk("sync_out", ck2, 1'b0);
    wr(REG_PWR, 32'h1);
    repeat (8) @(posedge clk);
    rd(REG_PWR, t); chk("pd_force", t[2], 1'b1);
    wr(REG_PWR, 32'h2);
    stop <= 1'b1;
    repeat (400) @(posedge clk);
    chk("pd_off", ssel, 1'b0);
    wr(REG_PWR, 32'h0);
    repeat (400) @(posedge clk);
    chk("pd_auto", ssel, 1'b1);
    stop <= 1'b0;
    wr(REG_CTRL, 32'h1);
    wr(REG_CKSUM, 32'h0);
    repeat (3) @(posedge clk);
    rd(REG_CKSUM, rdat_hold_dummy);
    t = rdat_hold_dummy;
    n = int'(so);
    repeat (5) @(posedge clk);
    chk("ramp_moves", 32'(so !== 16'(n)), 32'h1);
    rd(REG_CKSUM, rdat_hold_dummy);
    chk("cksum_moves", 32'(t !== rdat_hold_dummy), 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
